/* rtl/tlrr_pkg.sv */
// Constants for the transceiver receiver reset and recovery status block.
// Assumes a single 50 MHz parallel clock and a core-side reset controller.
//
// Contract
// - When lock-to-data is selected the clock recovery switches to data lock and aligns; in automatic mode the code ignores it and follows the link.
// - Synthesizer lock drops when the reference is lost and rises once relocked.
// - In PCIe and Basic modes a signal-detect output flags link presence.
// - In automatic mode loss of link drops frequency lock as recovery falls back.
// - During recovery frequency lock may toggle between reference and data lock.
package tlrr_pkg;

	// ==========================================================
	// Functional modes
	typedef enum logic [1:0]
	{
		TLRR_MODE_BASIC = 2'h0,
		TLRR_MODE_PCIE  = 2'h1,
		TLRR_MODE_OTHER = 2'h2
	} tlrr_mode_t;

	// ==========================================================
	// Recovery state machine
	typedef enum logic [1:0]
	{
		TLRR_ST_REF  = 2'h0,
		TLRR_ST_DATA = 2'h1,
		TLRR_ST_LOCK = 2'h2
	} tlrr_state_t;

	// ==========================================================
	// Register offsets (plain port)
	localparam logic [3:0]  TLRR_REG_CTRL   = 4'h0;
	localparam logic [3:0]  TLRR_REG_STATUS = 4'h1;
	localparam logic [3:0]  TLRR_REG_LOSS   = 4'h2;

	// Control field positions
	localparam int          TLRR_CTRL_AUTO  = 0;
	localparam int          TLRR_CTRL_LTD   = 1;
	localparam int          TLRR_CTRL_MODE  = 2;
	localparam logic [7:0]  TLRR_CTRL_RESET = 8'h01;

	// ==========================================================
	// Timing: signal detect settle and frequency acquisition
	localparam int          TLRR_CLK_MHZ     = 50;
	localparam int          TLRR_ACQ_NS      = 400;
	localparam int          TLRR_ACQ_CYCLES  = (TLRR_ACQ_NS * TLRR_CLK_MHZ) / 1000;
	localparam int          TLRR_SD_NS       = 100;
	localparam int          TLRR_SD_CYCLES   = (TLRR_SD_NS * TLRR_CLK_MHZ) / 1000;

endpackage

/* rtl/tlrr_sync.sv */
// Two-flop synchroniser for asynchronous transceiver status pins.
// Assumes the pins change slower than the parallel clock.
`timescale 1ns/1ns
module tlrr_sync
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	// Data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			stage1 <= '0;
			sync_o <= '0;
		end
		else if (ce_i)
		begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end

endmodule

/* rtl/tlrr_core.sv */
// Receiver clock-recovery lock status and signal detect of the transceiver.
// Assumes a core reset controller drives the lock controls and digital reset.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ns
module tlrr_core
	import tlrr_pkg::*;
#(
	parameter int ACQ_CYCLES = tlrr_pkg::TLRR_ACQ_CYCLES,
	parameter int SD_CYCLES  = tlrr_pkg::TLRR_SD_CYCLES
)
(
	// Clock, reset, enable
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// Register port
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// Lock controls from core
	input  wire logic       lock_to_reference_mode_i,
	input  wire logic       lock_to_data_i,
	input  wire logic       rx_digital_reset_i,
	input  wire logic       force_elec_idle_i,
	// Analog status pins
	input  wire logic       ref_clock_ok_i,
	input  wire logic       serial_activity_i,
	// Status to core
	output logic            synth_locked_o,
	output logic            freq_locked_o,
	output logic            signal_detect_o,
	output logic            data_lock_mode_o,
	output logic            rx_ready_o,
	output logic            tx_idle_o
);

	// ==========================================================
	// Elaboration checks
	if (ACQ_CYCLES < 1 || ACQ_CYCLES > 255 || SD_CYCLES < 1 || SD_CYCLES > 255)
	begin : g_count_check
		$error("tlrr_core: acquisition counts out of range");
	end

	// ==========================================================
	// Counter end test, shared by the settle counters
	function automatic logic cnt_hit(input logic [7:0] cnt, input int limit);
		return cnt == 8'(limit);
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic [1:0] pins_sync;
	logic       ref_ok;
	logic       activity;

	tlrr_sync #(.WIDTH(2)) u_sync
	(
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.async_i ({ref_clock_ok_i, serial_activity_i}),
		.sync_o  (pins_sync)
	);

	assign ref_ok   = pins_sync[1];
	assign activity = pins_sync[0];

	// ==========================================================
	// Control register
	logic [7:0]  ctrl;
	logic        auto_mode;
	logic        sw_ltd;
	tlrr_mode_t  func_mode;
	logic        ctrl_wr;

	assign auto_mode = ctrl[TLRR_CTRL_AUTO];
	assign sw_ltd    = ctrl[TLRR_CTRL_LTD];
	assign func_mode = tlrr_mode_t'(ctrl[TLRR_CTRL_MODE +: 2]);
	assign ctrl_wr   = wr_i && (addr_i == TLRR_REG_CTRL);

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			ctrl <= TLRR_CTRL_RESET;
		else if (ce_i && ctrl_wr)
			ctrl <= wdata_i;
	end

	// ==========================================================
	// Synthesizer lock follows the reference, relocks after acquisition
	logic [7:0] synth_cnt;
	logic       synth_done;

	assign synth_done = cnt_hit(synth_cnt, ACQ_CYCLES);

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			synth_cnt      <= 8'h00;
			synth_locked_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (!ref_ok)
			begin
				synth_cnt      <= 8'h00;
				synth_locked_o <= 1'b0;
			end
			else if (!synth_done)
				synth_cnt <= synth_cnt + 8'h01;
			else
				synth_locked_o <= 1'b1;
		end
	end

	// ==========================================================
	// Signal detect, qualified for a settle time
	logic [7:0] sd_cnt;
	logic       sd_mode_ok;

	assign sd_mode_ok = (func_mode == TLRR_MODE_PCIE) || (func_mode == TLRR_MODE_BASIC);

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			sd_cnt          <= 8'h00;
			signal_detect_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (!activity || !sd_mode_ok)
			begin
				sd_cnt          <= 8'h00;
				signal_detect_o <= 1'b0;
			end
			else if (!cnt_hit(sd_cnt, SD_CYCLES))
				sd_cnt <= sd_cnt + 8'h01;
			else
				signal_detect_o <= 1'b1;
		end
	end

	// ==========================================================
	// Clock recovery state machine
	tlrr_state_t state;
	tlrr_state_t next_state;
	logic [7:0]  cdr_cnt;
	logic        cdr_done;
	logic        want_ltd;
	logic        link_ok;

	assign cdr_done = cnt_hit(cdr_cnt, ACQ_CYCLES);
	assign link_ok  = activity && synth_locked_o;
	assign want_ltd = auto_mode ? link_ok
		: ((lock_to_data_i || sw_ltd) && !lock_to_reference_mode_i && synth_locked_o);

	always_comb
	begin
		next_state = state;
		unique case (state)
			TLRR_ST_REF:
				if (want_ltd && (cdr_done || !auto_mode))
					next_state = TLRR_ST_DATA;
			TLRR_ST_DATA:
				if (!want_ltd)
					next_state = TLRR_ST_REF;
				else if (cdr_done)
					next_state = TLRR_ST_LOCK;
			TLRR_ST_LOCK:
				if (!want_ltd)
					next_state = TLRR_ST_REF;
			default:
				next_state = TLRR_ST_REF;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state   <= TLRR_ST_REF;
			cdr_cnt <= 8'h00;
		end
		else if (ce_i)
		begin
			state <= next_state;
			if (next_state != state || !synth_locked_o)
				cdr_cnt <= 8'h00;
			else if (!cdr_done)
				cdr_cnt <= cdr_cnt + 8'h01;
		end
	end

	// ==========================================================
	// Status outputs
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			freq_locked_o    <= 1'b0;
			data_lock_mode_o <= 1'b0;
			rx_ready_o       <= 1'b0;
			tx_idle_o        <= 1'b1;
		end
		else if (ce_i)
		begin
			freq_locked_o    <= (next_state == TLRR_ST_LOCK) ||
				(!auto_mode && next_state == TLRR_ST_DATA);
			data_lock_mode_o <= (next_state != TLRR_ST_REF);
			rx_ready_o       <= (next_state != TLRR_ST_REF) && !rx_digital_reset_i;
			tx_idle_o        <= force_elec_idle_i;
		end
	end

	// ==========================================================
	// Read port, data one cycle after the strobe
	logic [7:0] status_word;
	logic [7:0] rd_mux;

	assign status_word = {1'b0, tx_idle_o, rx_ready_o, data_lock_mode_o,
		signal_detect_o, freq_locked_o, synth_locked_o, ref_ok};
	assign rd_mux = (addr_i == TLRR_REG_CTRL)   ? ctrl :
		(addr_i == TLRR_REG_STATUS) ? status_word :
		(addr_i == TLRR_REG_LOSS)   ? {6'h00, state} : 8'h00;

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			rdata_o <= 8'h00;
		else if (ce_i)
			rdata_o <= rd_i ? rd_mux : 8'h00;
	end

endmodule

/* bench/tlrr_core_assertions.sv */
// Port checks on the transceiver lock status block.
// Assumes a bind to tlrr_core; clock enable low for a few cycles at most.
`timescale 1ns/1ns
module tlrr_core_assertions
(
	// Watched ports
	input wire logic       clock_i,
	input wire logic       rst_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       ref_clock_ok_i,
	input wire logic       serial_activity_i,
	input wire logic       synth_locked_o,
	input wire logic       freq_locked_o,
	input wire logic       signal_detect_o,
	input wire logic       data_lock_mode_o
);
	// ==========================================================
	// Checks
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	chk_synth_drop: assert property ($fell(ref_clock_ok_i) |-> ##[1:8] !synth_locked_o)
		else $error("synth lock held after reference loss");
	chk_synth_rise: assert property ($rose(synth_locked_o) |-> ref_clock_ok_i)
		else $error("synth lock rose without reference");
	chk_detect_rise: assert property ($rose(signal_detect_o) |-> serial_activity_i)
		else $error("signal detect rose without activity");
	chk_detect_drop: assert property ($fell(serial_activity_i) |-> ##[1:8] !signal_detect_o)
		else $error("signal detect held after activity loss");
	chk_freq_fall: assert property ($fell(data_lock_mode_o) |-> ##[0:1] !freq_locked_o)
		else $error("freq lock held after data lock loss");
	chk_freq_rise: assert property ($rose(freq_locked_o) |-> data_lock_mode_o)
		else $error("freq lock rose outside data lock");
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data without read strobe");
endmodule

/* bench/tlrr_core_ctrl_model.sv */
// Core reset controller model driving the lock controls.
// Assumes status levels from tlrr_core on the same clock.
`timescale 1ns/1ns
module tlrr_core_ctrl_model
#(
	parameter int REF_WAIT  = 6,
	parameter int DATA_WAIT = 6
)
(
	// Clock, reset, requests
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic auto_i,
	input  wire logic slip_i,
	// Status in
	input  wire logic synth_locked_i,
	input  wire logic freq_locked_i,
	// Controls out
	output logic      ltr_o,
	output logic      ltd_o,
	output logic      rx_reset_o,
	output logic      idle_o
);
	// ==========================================================
	// Sequencer
	int  cnt   = 0;
	int  pulse = 0;
	wire restart = rst_i || !synth_locked_i;
	always_ff @(posedge clock_i)
	begin
		idle_o     <= rst_i;
		cnt        <= restart ? 0 : cnt + int'(cnt < 999);
		ltr_o      <= !auto_i && cnt < REF_WAIT;
		ltd_o      <= !auto_i && cnt >= REF_WAIT;
		pulse      <= slip_i ? 2 : pulse - int'(pulse > 0);
		rx_reset_o <= restart || cnt < REF_WAIT + DATA_WAIT || !freq_locked_i
			|| slip_i || pulse > 1;
	end
endmodule

/* bench/transceiver_link_reset_recovery_tb_top.sv */
// Self-checking bench for the transceiver lock status block.
// Assumes the core controller model and a bound checker.
`timescale 1ns/1ns
module transceiver_link_reset_recovery_tb_top;
	import tlrr_pkg::*;
	logic       clock_i = 1'b0;
	logic       rst_i   = 1'b1;
	logic       ce_i    = 1'b1;
	logic       wr_i    = 1'b0;
	logic       rd_i    = 1'b0;
	logic       ref_clock_ok_i    = 1'b0;
	logic       serial_activity_i = 1'b0;
	logic       slip    = 1'b0;
	logic       auto_m  = 1'b1;
	logic [3:0] addr_i  = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic       lock_to_reference_mode_i, lock_to_data_i, rx_digital_reset_i, force_elec_idle_i;
	logic       synth_locked_o, freq_locked_o, signal_detect_o, data_lock_mode_o;
	int         n_errors = 0;
	int         n_tests  = 0;
	int         seed     = 32'hfa42f593;
	always #10 clock_i = ~clock_i;
	tlrr_core #(.ACQ_CYCLES(4), .SD_CYCLES(2)) i_dut (.clock_i, .rst_i, .ce_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .lock_to_reference_mode_i, .lock_to_data_i,
		.rx_digital_reset_i, .force_elec_idle_i, .ref_clock_ok_i, .serial_activity_i,
		.synth_locked_o, .freq_locked_o, .signal_detect_o, .data_lock_mode_o,
		.rx_ready_o(), .tx_idle_o());
	tlrr_core_ctrl_model i_core (.clock_i, .rst_i, .auto_i(auto_m), .slip_i(slip),
		.synth_locked_i(synth_locked_o), .freq_locked_i(freq_locked_o),
		.ltr_o(lock_to_reference_mode_i), .ltd_o(lock_to_data_i),
		.rx_reset_o(rx_digital_reset_i), .idle_o(force_elec_idle_i));
	// ==========================================================
	// Tasks
	task automatic test_done();
		$display("errors=%0d tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		@(posedge clock_i);
	endtask
	function automatic logic pick(input int w);
		return w == 0 ? synth_locked_o : w == 1 ? freq_locked_o
			: w == 2 ? signal_detect_o : rx_digital_reset_i;
	endfunction
	task automatic wait_for(input int w, input logic lvl);
		int i;
		for (i = 0; i < 3000 && pick(w) !== lvl; i++)
			@(posedge clock_i);
		if (i == 3000)
		begin
			n_errors++;
			test_done();
		end
	endtask
	// ==========================================================
	// Scenarios
	initial
	begin
		logic [7:0] v;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		reg_rd(TLRR_REG_CTRL, v);
		check(v, TLRR_CTRL_RESET);
		reg_rd(4'hf, v);
		check(v, 8'h00);
		for (int k = 0; k < 6; k++)
		begin
			ref_clock_ok_i <= 1'b0;
			wait_for(0, 1'b0);
			auto_m <= k[0];
			reg_wr(TLRR_REG_CTRL, {4'h0, 1'b0, 1'($random(seed)), 1'($random(seed)), k[0]});
			repeat (2 + ($random(seed) & 7)) @(posedge clock_i);
			ref_clock_ok_i <= 1'b1;
			serial_activity_i <= 1'b1;
			wait_for(0, 1'b1);
			wait_for(3, 1'b0);
			reg_rd(TLRR_REG_STATUS, v);
			check(v, 8'h3f);
			if (k[0])
			begin
				serial_activity_i <= 1'b0;
				wait_for(1, 1'b0);
				wait_for(2, 1'b0);
				check({7'h0, data_lock_mode_o}, 8'h00);
				@(posedge clock_i);
				check({7'h0, rx_digital_reset_i}, 8'h01);
				serial_activity_i <= 1'b1;
				wait_for(1, 1'b1);
				wait_for(3, 1'b0);
				check({6'h0, freq_locked_o, signal_detect_o}, 8'h03);
			end
			slip <= 1'b1;
			@(posedge clock_i);
			slip <= 1'b0;
			@(posedge clock_i);
			check({7'h0, rx_digital_reset_i}, 8'h01);
			@(posedge clock_i);
			check({7'h0, rx_digital_reset_i}, 8'h01);
			wait_for(3, 1'b0);
			reg_rd(TLRR_REG_STATUS, v);
			check(v, 8'h3f);
		end
		reg_wr(TLRR_REG_CTRL, 8'h09);
		wait_for(2, 1'b0);
		ce_i <= 1'b0;
		ref_clock_ok_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		check({7'h0, synth_locked_o}, 8'h01);
		ce_i <= 1'b1;
		wait_for(0, 1'b0);
		test_done();
	end
endmodule
bind tlrr_core tlrr_core_assertions i_chk (.clock_i, .rst_i, .rd_i, .rdata_o, .ref_clock_ok_i,
	.serial_activity_i, .synth_locked_o, .freq_locked_o, .signal_detect_o, .data_lock_mode_o);
